// [src/vrm_top.sv]
// variable-resolution monitor: registers, per-channel cores, output words
// How it works
// [RL1] each converter channel has its own monitor, enabled and set up separately
// [RL2] resolution stays between 9 and 14 bits
// [RL3] no gain change, only the word's resolution changes
// [RL4] complex mode offers 25% or 43% passband, real mode fixed 25%
// [RL5] mode and bandwidth fields in the mode register define the forbidden zones
// [RL6] decision uses peak level of the signal in the forbidden zones
// [RL7] above -30 dBFS, each 6 dB more drops one bit
// [RL8] 14,13,12,11,10 then 9 bits from -6 to 0 dBFS
// [RL9] control-bit select registers insert status bits into the output stream
// [RL10] three control bits used means resolution parameter becomes 13
// [RL11] flag reads 1 while resolution is reduced, 0 at full
// [RL12] penalty code 00=14, 01=13, 10=12/11, 11=10/9 bits
// [RL13] centre set by tune bits 3..0 in sixteenths of the sample rate
// [RL14] complex mode centre spans 1/16 to 15/16 of the sample rate
// [RL15] software writes only tune codes 2 to 6 in real mode
// [RL16] real passband is centre plus and minus one eighth of the rate
// [RL17] dropped low bits forced to zero, word width unchanged
module vrm_top #(
  parameter int PEAK_WIN = vrm_pkg::VRM_PEAK_WIN
) (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        ce_in,
  input  wire logic [1:0]  chan_sel_in,
  input  wire logic [11:0] reg_addr_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  input  wire logic [7:0]  reg_wdata_in,
  output logic [7:0]       reg_rdata_out,
  input  wire logic [13:0] samp_a_in,
  input  wire logic [13:0] samp_b_in,
  output logic [13:0]      data_a_out,
  output logic [13:0]      data_b_out,
  output logic [2:0]       ctrl_a_out,
  output logic [2:0]       ctrl_b_out,
  output logic [3:0]       conv_res_a_out,
  output logic [3:0]       conv_res_b_out,
  output logic [3:0]       res_a_out,
  output logic [3:0]       res_b_out
);
  import vrm_pkg::*;

  typedef struct packed {
    logic [1:0][7:0]  mode;
    logic [1:0][7:0]  tune;
    logic [1:0][7:0]  csa;
    logic [1:0][7:0]  csb;
    logic [1:0][13:0] data;
    logic [1:0][2:0]  ctrl;
    logic [1:0][3:0]  conv;
    logic [7:0]       rdata;
  } vrm_top_st_t;

  vrm_top_st_t s_ff, nxt_s;
  logic [13:0] samp [2];
  logic [3:0]  res_w [2];
  logic        rch;

  assign samp[0] = samp_a_in;
  assign samp[1] = samp_b_in;

  // mask keeping the top res bits of a 14-bit word
  function automatic logic [13:0] keep_mask(input logic [3:0] res);
    keep_mask = 14'h3fff << (VRM_RES_FULL - res);
  endfunction

  // two-bit penalty code from resolution
  function automatic logic [1:0] pen_code(input logic [3:0] res);
    if (res >= VRM_RES_FULL) pen_code = 2'b00;
    else if (res == 4'hd) pen_code = 2'b01;
    else if (res >= 4'hb) pen_code = 2'b10;
    else pen_code = 2'b11;
  endfunction

  // value of one control bit from its source select
  function automatic logic cbit(input logic [1:0] sel, input logic [3:0] res);
    logic [1:0] p;
    p = pen_code(res);
    unique case (vrm_csrc_t'(sel))
      VRM_CS_OFF:  cbit = 1'b0;
      VRM_CS_FLAG: cbit = (res != VRM_RES_FULL);
      VRM_CS_PEN0: cbit = p[0];
      VRM_CS_PEN1: cbit = p[1];
    endcase
  endfunction

  // one monitor core per converter channel
  generate
    for (genvar c = 0; c < 2; c++) begin : g_ch
      vrm_zone_core #(.PEAK_WIN(PEAK_WIN)) u_core (
        .clk_in  (clk_in),
        .rst_in  (rst_in),
        .ce_in   (ce_in),
        .en_in   (s_ff.mode[c][VRM_MODE_EN_BIT]), // see [RL1]
        .cplx_in (s_ff.mode[c][VRM_MODE_CPX_BIT]),
        .bw43_in (s_ff.mode[c][VRM_MODE_CPX_BIT] & s_ff.mode[c][VRM_MODE_BW_BIT]), // see [RL4]
        .tune_in (s_ff.tune[c][VRM_TUNE_LSB +: VRM_TUNE_W]),
        .i_in    (samp[c]),
        .q_in    (samp[1-c]),
        .res_out (res_w[c])
      );
    end
  endgenerate

  // channel whose registers are read back
  assign rch = ~chan_sel_in[0];

  // register writes, read-back and output word formation
  always_comb begin
    nxt_s = s_ff;
    for (int c = 0; c < 2; c++) begin
      if (reg_wr_in && chan_sel_in[c]) begin // see [RL1]
        if (reg_addr_in == VRM_ADDR_MODE_BW) nxt_s.mode[c] = reg_wdata_in; // see [RL5]
        if (reg_addr_in == VRM_ADDR_TUNE) nxt_s.tune[c] = reg_wdata_in; // see [RL13]
        if (reg_addr_in == VRM_ADDR_CSEL_A) nxt_s.csa[c] = reg_wdata_in; // see [RL9]
        if (reg_addr_in == VRM_ADDR_CSEL_B) nxt_s.csb[c] = reg_wdata_in;
      end
      nxt_s.data[c] = samp[c] & keep_mask(res_w[c]); // see [RL3] see [RL17] see [RL2]
      nxt_s.ctrl[c][0] = cbit(s_ff.csa[c][VRM_CS0_LSB +: 2], res_w[c]); // see [RL9] see [RL11]
      nxt_s.ctrl[c][1] = cbit(s_ff.csa[c][VRM_CS1_LSB +: 2], res_w[c]); // see [RL12]
      nxt_s.ctrl[c][2] = cbit(s_ff.csb[c][VRM_CS2_LSB +: 2], res_w[c]);
      nxt_s.conv[c] = VRM_RES_FULL;
      if (s_ff.csa[c][VRM_CS0_LSB +: 2] != 2'b00 && s_ff.csa[c][VRM_CS1_LSB +: 2] != 2'b00
          && s_ff.csb[c][VRM_CS2_LSB +: 2] != 2'b00) begin
        nxt_s.conv[c] = VRM_RES_N3; // see [RL10]
      end
    end
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        VRM_ADDR_MODE_BW: nxt_s.rdata = s_ff.mode[rch];
        VRM_ADDR_TUNE:    nxt_s.rdata = s_ff.tune[rch];
        VRM_ADDR_CSEL_A:  nxt_s.rdata = s_ff.csa[rch];
        VRM_ADDR_CSEL_B:  nxt_s.rdata = s_ff.csb[rch];
        default:          nxt_s.rdata = 8'h00;
      endcase
    end
  end

  // state register, frozen while clock enable is low
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_ff <= '{mode: {2{VRM_RST_MODE}}, tune: {2{VRM_RST_TUNE}}, csa: {2{VRM_RST_CSEL}},
                csb: {2{VRM_RST_CSEL}}, data: '0, ctrl: '0, conv: {2{VRM_RES_FULL}}, rdata: 8'h00};
    end else if (ce_in) begin
      s_ff <= nxt_s;
    end
  end

  assign reg_rdata_out  = s_ff.rdata;
  assign data_a_out     = s_ff.data[0];
  assign data_b_out     = s_ff.data[1];
  assign ctrl_a_out     = s_ff.ctrl[0];
  assign ctrl_b_out     = s_ff.ctrl[1];
  assign conv_res_a_out = s_ff.conv[0];
  assign conv_res_b_out = s_ff.conv[1];
  assign res_a_out      = res_w[0];
  assign res_b_out      = res_w[1];

  // per-channel checks
  generate
    for (genvar c = 0; c < 2; c++) begin : g_chk
      property p_res_range;
        @(posedge clk_in) disable iff (rst_in)
          res_w[c] >= 4'h9 && res_w[c] <= 4'he;
      endproperty
      a_res_range: assert property (p_res_range) else $error("resolution out of 9..14"); // see [RL2]

      property p_trunc;
        @(posedge clk_in) disable iff (rst_in)
          ce_in |=> s_ff.data[c] == ($past(samp[c]) & (14'h3fff << (4'he - $past(res_w[c]))));
      endproperty
      a_trunc: assert property (p_trunc) else $error("low bits not zeroed as resolution asks"); // see [RL17]

      property p_no_gain;
        @(posedge clk_in) disable iff (rst_in)
          ce_in && res_w[c] == 4'he |=> s_ff.data[c] == $past(samp[c]);
      endproperty
      a_no_gain: assert property (p_no_gain) else $error("full resolution word altered"); // see [RL3]

      property p_flag;
        @(posedge clk_in) disable iff (rst_in)
          ce_in && s_ff.csa[c][1:0] == 2'b01 |=> s_ff.ctrl[c][0] == ($past(res_w[c]) != 4'he);
      endproperty
      a_flag: assert property (p_flag) else $error("reduced flag wrong"); // see [RL11]

      property p_pen;
        @(posedge clk_in) disable iff (rst_in)
          ce_in && s_ff.csa[c][5:4] == 2'b11 && res_w[c] <= 4'ha |=> s_ff.ctrl[c][1];
      endproperty
      a_pen: assert property (p_pen) else $error("penalty high bit wrong"); // see [RL12]

      property p_conv;
        @(posedge clk_in) disable iff (rst_in)
          ce_in && s_ff.csa[c][1:0] == 2'b00 |=> s_ff.conv[c] == 4'he;
      endproperty
      a_conv: assert property (p_conv) else $error("resolution parameter must stay 14"); // see [RL10]

      property p_wr_mode;
        @(posedge clk_in) disable iff (rst_in)
          ce_in && reg_wr_in && chan_sel_in[c] && reg_addr_in == 12'h430
          |=> s_ff.mode[c] == $past(reg_wdata_in);
      endproperty
      a_wr_mode: assert property (p_wr_mode) else $error("mode write lost"); // see [RL5]

      property p_off;
        @(posedge clk_in) disable iff (rst_in)
          (ce_in && !s_ff.mode[c][0]) [*2] |-> res_w[c] == 4'he;
      endproperty
      a_off: assert property (p_off) else $error("disabled monitor must give 14 bits"); // see [RL1]
    end
  endgenerate
endmodule

// [pkg/vrm_pkg.sv]
// constants and types shared by the resolution monitor files
package vrm_pkg;
  // register offsets
  localparam logic [11:0] VRM_ADDR_MODE_BW = 12'h430;
  localparam logic [11:0] VRM_ADDR_TUNE    = 12'h434;
  localparam logic [11:0] VRM_ADDR_CSEL_A  = 12'h559;
  localparam logic [11:0] VRM_ADDR_CSEL_B  = 12'h55a;
  // reset values
  localparam logic [7:0]  VRM_RST_MODE     = 8'h00;
  localparam logic [7:0]  VRM_RST_TUNE     = 8'h04;
  localparam logic [7:0]  VRM_RST_CSEL     = 8'h00;
  // mode register fields
  localparam int          VRM_MODE_EN_BIT  = 0;
  localparam int          VRM_MODE_CPX_BIT = 1;
  localparam int          VRM_MODE_BW_BIT  = 2;
  // tune register field, bits 3..0
  localparam int          VRM_TUNE_LSB     = 0;
  localparam int          VRM_TUNE_W       = 4;
  // legal tuning span in real mode, kept by software
  localparam logic [3:0]  VRM_REAL_TUNE_LO = 4'h2;
  localparam logic [3:0]  VRM_REAL_TUNE_HI = 4'h6;
  // control-bit source fields: select a 1:0 -> bit0, 5:4 -> bit1; select b 1:0 -> bit2
  localparam int          VRM_CS0_LSB      = 0;
  localparam int          VRM_CS1_LSB      = 4;
  localparam int          VRM_CS2_LSB      = 0;
  // resolutions in bits
  localparam logic [3:0]  VRM_RES_FULL     = 4'he;
  localparam logic [3:0]  VRM_RES_MIN      = 4'h9;
  localparam logic [3:0]  VRM_RES_N3       = 4'hd;
  // magnitude thresholds of a 14-bit word: -30,-24,-18,-12,-6 dBFS
  localparam int          VRM_NTHR         = 5;
  localparam logic [4:0][13:0] VRM_THR     = {14'h1009, 14'h080b, 14'h0408, 14'h0205, 14'h0103};
  // peak window in samples
  localparam int          VRM_PEAK_WIN     = 64;
  // rotation table scale shift
  localparam int          VRM_LUT_SHIFT    = 7;
  // control-bit sources
  typedef enum logic [1:0] {
    VRM_CS_OFF  = 2'b00,
    VRM_CS_FLAG = 2'b01,
    VRM_CS_PEN0 = 2'b10,
    VRM_CS_PEN1 = 2'b11
  } vrm_csrc_t;
endpackage

// [src/vrm_zone_core.sv]
// one channel: zone extraction, peak hold and resolution decision
module vrm_zone_core #(
  parameter int PEAK_WIN = vrm_pkg::VRM_PEAK_WIN
) (
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  input  wire logic              ce_in,
  input  wire logic              en_in,
  input  wire logic              cplx_in,
  input  wire logic              bw43_in,
  input  wire logic [3:0]        tune_in,
  input  wire logic signed [13:0] i_in,
  input  wire logic signed [13:0] q_in,
  output logic [3:0]             res_out
);
  import vrm_pkg::*;
  localparam int WW = $clog2(PEAK_WIN);
  localparam logic [WW-1:0] WIN_LAST = WW'(PEAK_WIN - 1);

  typedef struct packed {
    logic [3:0]         ph;
    logic signed [14:0] rot;
    logic signed [14:0] prev;
    logic [13:0]        peak;
    logic [13:0]        hold;
    logic [WW-1:0]      win;
    logic [3:0]         res;
  } vrm_core_st_t;

  vrm_core_st_t s_ff, nxt_s;
  logic signed [22:0] prod;
  logic signed [15:0] diff;
  logic [15:0]        mag;
  logic [13:0]        mag14;
  logic signed [13:0] qv;

  // cosine in 1/16 turn steps, scale 127
  function automatic logic signed [7:0] cos_lut(input logic [3:0] k);
    unique case (k)
      4'h0: cos_lut = 8'h7f;
      4'h1: cos_lut = 8'h75;
      4'h2: cos_lut = 8'h5a;
      4'h3: cos_lut = 8'h31;
      4'h4: cos_lut = 8'h00;
      4'h5: cos_lut = 8'hcf;
      4'h6: cos_lut = 8'ha6;
      4'h7: cos_lut = 8'h8b;
      4'h8: cos_lut = 8'h81;
      4'h9: cos_lut = 8'h8b;
      4'ha: cos_lut = 8'ha6;
      4'hb: cos_lut = 8'hcf;
      4'hc: cos_lut = 8'h00;
      4'hd: cos_lut = 8'h31;
      4'he: cos_lut = 8'h5a;
      4'hf: cos_lut = 8'h75;
    endcase
  endfunction

  // number of dBFS steps the peak lies above
  function automatic logic [2:0] thr_count(input logic [13:0] m);
    thr_count = 3'h0;
    for (int t = 0; t < VRM_NTHR; t++) begin
      if (m > VRM_THR[t]) thr_count = thr_count + 3'h1;
    end
  endfunction

  // shift to the mask centre, take out-of-band part, hold peak
  always_comb begin
    nxt_s = s_ff;
    qv    = cplx_in ? q_in : 14'sh0000;
    prod  = i_in * cos_lut(s_ff.ph) + qv * cos_lut(s_ff.ph - 4'h4);
    nxt_s.ph   = s_ff.ph + tune_in; // see [RL13] see [RL14] see [RL16]
    nxt_s.rot  = prod[21:VRM_LUT_SHIFT];
    nxt_s.prev = s_ff.rot;
    diff = {s_ff.rot[14], s_ff.rot} - {s_ff.prev[14], s_ff.prev}; // see [RL5]
    if (bw43_in) diff = diff >>> 1; // wider passband, see [RL4]
    mag   = diff[15] ? 16'(-diff) : 16'(diff);
    mag14 = (mag > 16'h3fff) ? 14'h3fff : mag[13:0];
    nxt_s.peak = (mag14 > s_ff.peak) ? mag14 : s_ff.peak; // see [RL6]
    nxt_s.win  = (s_ff.win == WIN_LAST) ? '0 : s_ff.win + 1'b1;
    if (s_ff.win == WIN_LAST) begin
      nxt_s.hold = nxt_s.peak;
      nxt_s.peak = 14'h0000;
    end
    nxt_s.res = VRM_RES_FULL - {1'b0, thr_count(s_ff.hold)}; // see [RL7] see [RL8]
    if (!en_in) begin
      nxt_s.peak = 14'h0000;
      nxt_s.hold = 14'h0000;
      nxt_s.res  = VRM_RES_FULL;
    end
  end

  // state register
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_ff <= '{ph: 4'h0, rot: 15'sh0, prev: 15'sh0, peak: 14'h0, hold: 14'h0,
                 win: '0, res: VRM_RES_FULL};
    end else if (ce_in) begin
      s_ff <= nxt_s;
    end
  end

  assign res_out = s_ff.res;

  property p_quiet_full;
    @(posedge clk_in) disable iff (rst_in)
      ce_in && en_in && s_ff.hold <= VRM_THR[0] |=> res_out == 4'he;
  endproperty
  a_quiet_full: assert property (p_quiet_full) else $error("quiet zones must give 14 bits"); // see [RL7]

  property p_loud_min;
    @(posedge clk_in) disable iff (rst_in)
      ce_in && en_in && s_ff.hold > VRM_THR[4] |=> res_out == 4'h9;
  endproperty
  a_loud_min: assert property (p_loud_min) else $error("top band must give 9 bits"); // see [RL8]

  property p_step;
    @(posedge clk_in) disable iff (rst_in)
      ce_in && en_in && s_ff.hold > VRM_THR[1] && s_ff.hold <= VRM_THR[2] |=> res_out == 4'hc;
  endproperty
  a_step: assert property (p_step) else $error("12 bits expected in third band"); // see [RL7]
endmodule

// [verif/vrm_rx_model.sv]
// receiving end of the sample stream: latches each word, control bits and width
module vrm_rx_model (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        ce_in,
  input  wire logic [13:0] data_in,
  input  wire logic [2:0]  ctrl_in,
  input  wire logic [3:0]  conv_res_in,
  output logic      [13:0] word_out,
  output logic      [2:0]  flags_out,
  output logic      [3:0]  n_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // one word a sample clock; the width parameter drops to 13 when all three control bits ride along, else stays 14
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      word_out  <= 14'h0000;
      flags_out <= 3'h0;
      n_out     <= 4'he;
    end else if (ce_in) begin
      word_out  <= data_in;
      flags_out <= ctrl_in;
      n_out     <= conv_res_in;
    end
  end
endmodule

// [verif/vrm_top_tb.sv]
// self-checking bench for the resolution monitor top
module vrm_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import vrm_pkg::*;

  logic        clk_in, rst_in, ce_in, reg_wr_in, reg_rd_in;
  logic [1:0]  chan_sel_in;
  logic [11:0] reg_addr_in;
  logic [7:0]  reg_wdata_in, reg_rdata_out, csa, csb;
  logic [13:0] samp_a_in, samp_b_in, data_a_out, data_b_out, rx_word;
  logic [2:0]  ctrl_a_out, ctrl_b_out, rx_flags;
  logic [3:0]  conv_res_a_out, conv_res_b_out, res_a_out, res_b_out, n_out, lo;
  int          fail_count, checks;

  vrm_top #(.PEAK_WIN(4)) vrm_top_inst (
    .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .chan_sel_in(chan_sel_in),
    .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .samp_a_in(samp_a_in), .samp_b_in(samp_b_in), .data_a_out(data_a_out), .data_b_out(data_b_out),
    .ctrl_a_out(ctrl_a_out), .ctrl_b_out(ctrl_b_out), .conv_res_a_out(conv_res_a_out),
    .conv_res_b_out(conv_res_b_out), .res_a_out(res_a_out), .res_b_out(res_b_out));

  vrm_rx_model vrm_rx_model_inst (
    .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .data_in(data_a_out), .ctrl_in(ctrl_a_out),
    .conv_res_in(conv_res_a_out), .word_out(rx_word), .flags_out(rx_flags), .n_out(n_out));

  // 50 MHz sample clock
  always #10ns clk_in = ~clk_in;

  task automatic cmp(input string nm, input logic [13:0] exp, input logic [13:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic close_out;
    if (fail_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // register write: request held for one taking edge
  task automatic wr(input logic [1:0] cs, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_in);
    chan_sel_in  <= cs;
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge clk_in);
    reg_wr_in    <= 1'b0;
  endtask

  // register read; data settles after the taking edge
  task automatic rd_chk(input logic [1:0] cs, input logic [11:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    chan_sel_in <= cs;
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge clk_in);
    reg_rd_in   <= 1'b0;
    @(negedge clk_in);
    cmp("reg_rdata", {6'h00, exp}, {6'h00, reg_rdata_out});
  endtask

  // expected control bit for a source code at a given resolution
  function automatic logic sbit(input logic [1:0] c, input logic [3:0] r);
    logic [1:0] p;
    p = r == VRM_RES_FULL ? 2'b00 : r == VRM_RES_N3 ? 2'b01 : r >= 4'hb ? 2'b10 : 2'b11;
    case (c)
      2'b01:   return r != VRM_RES_FULL;
      2'b10:   return p[0];
      2'b11:   return p[1];
      default: return 1'b0;
    endcase
  endfunction

  // drive n samples (half-rate tone, or complex quarter-rate tone) and check every word but the last
  task automatic run(input int n, input logic [13:0] amp, input logic cpx, output logic [3:0] low);
    logic [13:0] a, b, pa, pb, e, pe;
    logic [3:0]  ra, rb;
    low = 4'he;
    for (int k = 0; k < n; k++) begin
      a = cpx ? (k % 4 == 0 ? amp : k % 4 == 2 ? -amp : 14'h0) : (k % 2 ? -amp : amp);
      b = cpx ? (k % 4 == 1 ? amp : k % 4 == 3 ? -amp : 14'h0) : a;
      @(posedge clk_in);
      samp_a_in <= a;
      samp_b_in <= b;
      @(negedge clk_in);
      if (k > 0) begin
        e = pa & (14'h3fff << (14 - ra));
        cmp("data_a", e, data_a_out);
        cmp("data_b", pb & (14'h3fff << (14 - rb)), data_b_out);
        cmp("ctrl_a", {11'h0, sbit(csb[1:0], ra), sbit(csa[5:4], ra), sbit(csa[1:0], ra)},
            {11'h0, ctrl_a_out});
        cmp("ctrl_b", {11'h0, sbit(csb[1:0], rb), sbit(csa[5:4], rb), sbit(csa[1:0], rb)},
            {11'h0, ctrl_b_out});
        cmp("res_a_span", 14'h1, {13'h0, ra >= VRM_RES_MIN && ra <= VRM_RES_FULL});
        if (k > 1) cmp("rx_word", pe, rx_word);
        pe = e;
      end
      pa = a;
      pb = b;
      ra = res_a_out;
      rb = res_b_out;
      if (res_a_out < low) low = res_a_out;
    end
  endtask

  // main sequence
  initial begin
    clk_in = 1'b0; rst_in = 1'b1; ce_in = 1'b1; reg_wr_in = 1'b0; reg_rd_in = 1'b0;
    chan_sel_in = 2'b00; reg_addr_in = 12'h000; reg_wdata_in = 8'h00;
    samp_a_in = 14'h0000; samp_b_in = 14'h0000; csa = 8'h00; csb = 8'h00;
    fail_count = 0; checks = 0;
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    @(negedge clk_in);
    cmp("res_a_rst", 14'he, {10'h0, res_a_out});
    rd_chk(2'b01, VRM_ADDR_MODE_BW, VRM_RST_MODE);
    rd_chk(2'b01, VRM_ADDR_TUNE, VRM_RST_TUNE);
    rd_chk(2'b01, VRM_ADDR_CSEL_A, VRM_RST_CSEL);
    rd_chk(2'b10, VRM_ADDR_CSEL_B, VRM_RST_CSEL);
    wr(2'b01, VRM_ADDR_MODE_BW, 8'h01);
    wr(2'b11, VRM_ADDR_CSEL_A, 8'h21);
    wr(2'b01, 12'h431, 8'h5a);
    rd_chk(2'b01, 12'h431, 8'h00);
    rd_chk(2'b10, VRM_ADDR_MODE_BW, 8'h00);
    rd_chk(2'b01, VRM_ADDR_CSEL_A, 8'h21);
    csa = 8'h21;
    // real mode keeps the reset tune code 4; a half-rate tone sits in the forbidden zone
    run(40, 14'h1f40, 1'b0, lo);
    cmp("res_a_cut", 14'h1, {13'h0, lo <= VRM_RES_N3});
    cmp("res_b_off", 14'he, {10'h0, res_b_out});
    cmp("conv_n2", 14'he, {10'h0, n_out});
    cmp("conv_b_n2", 14'he, {10'h0, conv_res_b_out});
    wr(2'b11, VRM_ADDR_CSEL_B, 8'h03);
    csb = 8'h03;
    run(40, 14'h0000, 1'b0, lo);
    cmp("res_a_quiet", 14'he, {10'h0, res_a_out});
    cmp("conv_n3", 14'hd, {10'h0, n_out});
    cmp("conv_b_n3", 14'hd, {10'h0, conv_res_b_out});
    // complex 43% band: tone on the centre keeps full resolution
    wr(2'b11, VRM_ADDR_MODE_BW, 8'h07);
    run(40, 14'h03e8, 1'b1, lo);
    run(16, 14'h03e8, 1'b1, lo);
    cmp("res_cpx43", 14'he, {10'h0, lo});
    // complex 25% band: half-rate tone outside, then retuned onto it
    wr(2'b11, VRM_ADDR_MODE_BW, 8'h03);
    run(40, 14'h1f40, 1'b0, lo);
    cmp("res_cpx25", 14'h1, {13'h0, lo <= VRM_RES_N3});
    wr(2'b11, VRM_ADDR_TUNE, 8'h08);
    run(40, 14'h1f40, 1'b0, lo);
    run(16, 14'h1f40, 1'b0, lo);
    cmp("res_tuned", 14'he, {10'h0, lo});
    // back to a legal real-mode tune code before leaving complex mode
    wr(2'b11, VRM_ADDR_TUNE, 8'h04);
    // disabled monitor passes words whole
    wr(2'b11, VRM_ADDR_MODE_BW, 8'h00);
    run(8, 14'h1f40, 1'b0, lo);
    cmp("res_off", 14'he, {10'h0, lo});
    // frozen clock enable ignores a write
    @(posedge clk_in);
    ce_in <= 1'b0;
    wr(2'b01, VRM_ADDR_TUNE, 8'h0f);
    @(posedge clk_in);
    ce_in <= 1'b1;
    rd_chk(2'b01, VRM_ADDR_TUNE, 8'h04);
    close_out();
  end

  // hang guard, well beyond the roughly 290 cycles the sequence needs
  initial begin
    #60us;
    fail_count++;
    close_out();
  end
endmodule
